// >>> bench/testbench.sv
/*
 Self-checking bench for the ternary transmit framer with a coder model.
 Assumes the register map and frame layout of the framer's header file.
*/
`timescale 1ns/1ps
`include "tmi_regs.vh"
module testbench;
   reg clk_sys = 1'b0;
   reg resetn = 1'b0;
   reg [7:0] reg_addr = 8'h00;
   reg [31:0] reg_wdata = 32'h0000_0000;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg pl_bit = 1'b0;
   reg pl_valid = 1'b0;
   reg slow = 1'b0;
   wire [31:0] reg_rdata;
   wire pl_ready, rs_bit, rs_valid, rs_ready, cd_bit, cd_valid, cd_last, cd_ready;
   wire [1:0] sym_code;
   wire sym_valid, frame_start;
   reg pb [0:63];
   reg [31:0] rv;
   int err_count = 0;
   int compares = 0;
   int cyc = 0;
   int pidx = 0;
   int ln, i, scr;

   initial forever #25 clk_sys = ~clk_sys;

   tmi_tx_framer DUT (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .pl_bit, .pl_valid, .pl_ready, .rs_bit, .rs_valid, .rs_ready, .cd_bit,
      .cd_valid, .cd_last, .cd_ready, .sym_code, .sym_valid, .frame_start);
   tmi_rs_model u_rs (.clk_sys, .resetn, .slow, .rs_bit, .rs_valid, .rs_ready,
      .cd_bit, .cd_valid, .cd_last, .cd_ready);

   // Payload source steps through its bit table as bits are taken
   always @(posedge clk_sys) begin
      if (pl_valid && pl_ready) begin
         pidx <= pidx + 1;
         pl_bit <= pb[(pidx + 1) % 64];
      end
   end

   // Cycle ceiling, well above the few frames sent
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         close_out;
      end
   end

   task close_out;
      $display("Checks %0d, mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error %0t: got %h, expected %h", $time, got, exp);
      end
   endtask

   task step;
      @(posedge clk_sys);
      #1;
   endtask

   task wr(input [7:0] a, input [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task rd(input [7:0] a);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask

   task idle;
      for (int j = 0; j < 3000; j++) begin
         rd(`TMI_ADDR_STAT);
         if (rv[0] === 1'b0)
            break;
      end
      chk(rv, 32'h0000_0008);
   endtask

   // Ternary code of a precoded pair, older bit first
   function [1:0] tm(input a, input b);
      tm = (a == b) ? `TMI_SYM_ZERO : (b ? `TMI_SYM_POS : `TMI_SYM_NEG);
   endfunction

   // Preamble source bit worked out from the complex base sequences in reals
   function bit pre(input int k);
      int n, ph;
      real a;
      n = k % 256;
      if (k < 2048) begin
         // Quarter turns of the product of two length-16 terms
         ph = (n % 4) * ((n % 16) / 4) + ((n / 16) % 4) * ((n / 16) / 4);
         a = 1.5707963267948966 * ph;
         pre = (($cos(a) + $sin(a)) >= 0.0) ^ (k >= 1792);
      end else begin
         // Sixteenth turns of the length-256 term; ties count as a one
         ph = (n % 16) * (n / 16);
         a = 0.39269908169872414 * ph;
         pre = ($cos(a) - $sin(a)) >= -1.0e-9;
      end
   endfunction

   function [45:0] hdr(input [1:0] s, input h, input [19:0] l);
      hdr = {2'h0, h ? l : 20'h0_0000, 6'h2D, 5'h00, h, 3'h0, h, 6'h00, s};
   endfunction

   // Walks one frame symbol by symbol against a private precoder
   task frame(input [45:0] h, input int n);
      int k, np;
      reg p1, p2, b, c;
      np = ((n + 1791) / 1792) * 1792;
      for (k = 0; k < 10 && frame_start !== 1'b1; k++)
         step;
      chk(frame_start, 1);
      for (k = 0; sym_valid === 1'b1 && k < 9000; k++) begin
         if (k < 2816 && k % 256 == 0)
            chk(sym_code, k == 1792 ? 2'h0 : 2'h1);
         // History restarts at every 256-symbol pattern, the header and the payload
         if ((k <= 2816 && k % 256 == 0) || k == 2862) begin
            p1 = 1'b0;
            p2 = 1'b0;
         end
         if (k < 2816)
            b = pre(k);
         else
            b = k < 2862 ? h[k - 2816] : (k - 2862 < n ? pb[k - 2862] : 1'b0);
         c = b ^ p2;
         if (k < 2816)
            chk(sym_code, tm(p2, c));
         else if (k < 2862)
            chk(sym_code, tm(p2, c));
         else
            chk(sym_code, tm(p2, c));
         p2 = p1;
         p1 = c;
         step;
      end
      chk(k, 2862 + np);
   endtask

   initial begin
      void'($urandom(79));
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      chk({sym_valid, sym_code}, 0);
      rd(`TMI_ADDR_STAT);
      chk(rv, 32'h0000_0008);
      rd(8'h0C);
      chk(rv, 0);
      ln = 1 + $urandom % 60;
      wr(`TMI_ADDR_LEN, ln);
      rd(`TMI_ADDR_LEN);
      chk(rv, ln);
      rd(`TMI_ADDR_CTRL);
      chk(rv, 0);
      $display("Test registers done");
      for (i = 0; i < 64; i++)
         pb[i] = $urandom % 2;
      pl_bit <= pb[0];
      pidx <= 0;
      pl_valid <= 1'b1;
      slow <= 1'b1;
      scr = $urandom % 4;
      wr(`TMI_ADDR_CTRL, scr * 16 + 3);
      frame(hdr(scr, 1'b1, ln), ln);
      idle;
      $display("Test payload frame done");
      wr(`TMI_ADDR_LEN, 0);
      wr(`TMI_ADDR_CTRL, 3);
      frame(hdr(0, 1'b0, 0), 0);
      idle;
      $display("Test empty frame done");
      wr(`TMI_ADDR_CTRL, 5);
      rd(`TMI_ADDR_STAT);
      chk(rv & 7, 2);
      wr(`TMI_ADDR_STAT, 2);
      rd(`TMI_ADDR_STAT);
      chk(rv, 32'h0000_0008);
      wr(`TMI_ADDR_CTRL, 1);
      wr(`TMI_ADDR_CTRL, 1);
      rd(`TMI_ADDR_STAT);
      chk(rv & 3, 3);
      wr(`TMI_ADDR_STAT, 2);
      idle;
      $display("Test refusals done");
      // Reset in mid-frame: outputs and status return to idle at once
      wr(`TMI_ADDR_CTRL, 1);
      repeat (100) @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      chk({sym_valid, frame_start, sym_code}, 0);
      rd(`TMI_ADDR_STAT);
      chk(rv, 32'h0000_0008);
      $display("Test reset done");
      close_out;
   end
endmodule

// >>> bench/tmi_rs_model.sv
/*
 Stand-in for the outside Reed-Solomon coder: returns each padded bit as a
 coded bit, in order. Assumes one clock, clk_sys, shared with the framer.
*/
`timescale 1ns/1ps
module tmi_rs_model (
   input wire clk_sys,
   input wire resetn,
   input wire slow,
   input wire rs_bit,
   input wire rs_valid,
   output reg rs_ready = 1'b0,
   output wire cd_bit,
   output wire cd_valid,
   output wire cd_last,
   input wire cd_ready
);
   reg mem_q [0:8191];
   int wr_q = 0;
   int rd_q = 0;
   reg tgl_q = 1'b0;
   // Identity coding, with random stalls in slow mode
   always @(posedge clk_sys) begin
      tgl_q <= !tgl_q;
      rs_ready <= !slow || ($urandom % 8 != 0);
      if (!resetn) begin
         wr_q <= 0;
         rd_q <= 0;
      end else begin
         if (rs_valid && rs_ready) begin
            mem_q[wr_q % 8192] <= rs_bit;
            wr_q <= wr_q + 1;
         end
         if (cd_valid && cd_ready)
            rd_q <= rd_q + 1;
      end
   end
   // An idle data line toggles so a stale bit cannot pass for data
   assign cd_valid = wr_q > rd_q;
   assign cd_bit = cd_valid ? mem_q[rd_q % 8192] : tgl_q;
   // Last only once a whole padded block has come back
   assign cd_last = cd_valid && rd_q == wr_q - 1 && !rs_valid && wr_q % 1792 == 0;
endmodule

// >>> bench/tmi_tx_framer_props.sv
/*
 Port checker for the ternary transmit framer.
 Assumes a bind onto tmi_tx_framer, one clock clk_sys.
*/
`timescale 1ns/1ps
`include "tmi_regs.vh"
module tmi_tx_framer_props (
   input wire clk_sys,
   input wire resetn,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_rdata,
   input wire pl_bit,
   input wire pl_valid,
   input wire pl_ready,
   input wire rs_bit,
   input wire rs_valid,
   input wire rs_ready,
   input wire cd_bit,
   input wire cd_valid,
   input wire cd_last,
   input wire cd_ready,
   input wire [1:0] sym_code,
   input wire sym_valid,
   input wire frame_start
);
   int run_q;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Length of the current symbol run; a counter avoids long repetitions
   always @(posedge clk_sys) begin
      if (!resetn || !sym_valid)
         run_q <= 0;
      else
         run_q <= run_q + 1;
   end
   start_valid_a: assert property (frame_start |-> sym_valid)
      else $error("frame start outside a frame");
   start_pulse_a: assert property (frame_start |=> !frame_start)
      else $error("frame start longer than one cycle");
   run_start_a: assert property ($rose(sym_valid) |-> frame_start)
      else $error("frame began without start pulse");
   frame_len_a: assert property ($fell(sym_valid) |-> run_q >= 2861)
      else $error("frame shorter than preamble and header");
   idle_zero_a: assert property (!sym_valid |-> sym_code == `TMI_SYM_ZERO)
      else $error("symbol outside a frame");
   code_legal_a: assert property (sym_code != 2'h2)
      else $error("illegal symbol code");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
   pad_pass_a: assert property (pl_valid && pl_ready |=>
      rs_valid && rs_bit == $past(pl_bit))
      else $error("payload bit not passed to coder");
   pad_ready_a: assert property (pl_ready |-> !rs_valid || rs_ready)
      else $error("payload taken while coder stalls");
   coder_hold_a: assert property (rs_valid && !rs_ready |=> rs_valid && $stable(rs_bit))
      else $error("coder bit dropped before taken");
endmodule
bind tmi_tx_framer tmi_tx_framer_props u_props (.clk_sys, .resetn, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata, .pl_bit, .pl_valid, .pl_ready, .rs_bit, .rs_valid,
   .rs_ready, .cd_bit, .cd_valid, .cd_last, .cd_ready, .sym_code, .sym_valid, .frame_start);

// >>> rtl/tmi_regs.vh
/*
 Register offsets, field positions, reset values and frame counts of the
 ternary mark-inversion transmit framer.
 Assumes inclusion by bare name from the framer, the bench and the port checker.
*/
`ifndef TMI_REGS_VH
`define TMI_REGS_VH

// Register byte offsets
`define TMI_ADDR_CTRL 8'h00
`define TMI_ADDR_LEN 8'h04
`define TMI_ADDR_STAT 8'h08

// Control register fields
`define TMI_CTRL_START 0
`define TMI_CTRL_PAYLOAD 1
`define TMI_CTRL_DISC 2
`define TMI_CTRL_SCR_LO 4
`define TMI_CTRL_SCR_HI 5
`define TMI_CTRL_RST 6'h00

// Status register fields
`define TMI_STAT_BUSY 0
`define TMI_STAT_REFUSED 1
`define TMI_STAT_UNDERRUN 2
`define TMI_STAT_ST_LO 3
`define TMI_STAT_ST_HI 7

// Payload length in bits
`define TMI_LEN_W 20
`define TMI_LEN_RST 20'h0_0000

// Frame section lengths in symbols; the padding block length in bits
`define TMI_SYNC_LEN 12'h800
`define TMI_SYNC_ALT 12'h700
`define TMI_CE_LEN 12'h300
`define TMI_HDR_LEN 12'h02E
`define TMI_PAD_BLK 11'h700

// Header field layout, sent from bit 0 upward
`define TMI_HDR_W 46
`define TMI_H_SCR 0
`define TMI_H_BITREV 2
`define TMI_H_TIP 3
`define TMI_H_PREFIX 4
`define TMI_H_REQPREFIX 6
`define TMI_H_NSEG 8
`define TMI_H_NSU 12
`define TMI_H_MODE 18
`define TMI_H_LEN 24
`define TMI_H_MIDAMBLE 44
`define TMI_H_SEGMENT_CONTINUED_FLAG 45

// Fixed header values
`define TMI_MODE_VAL 6'h2D
`define TMI_NSEG_ONE 4'h1
`define TMI_NSEG_NONE 4'h0
`define TMI_NSU_ONE 6'h01
`define TMI_NSU_NONE 6'h00
`define TMI_PREFIX_VAL 2'h0

// Ternary symbol codes
`define TMI_SYM_ZERO 2'h0
`define TMI_SYM_POS 2'h1
`define TMI_SYM_NEG 2'h3

`endif

// >>> rtl/tmi_tx_framer.v
/*
 Ternary mark-inversion transmit framer: preamble generation, fixed header,
 zero padding toward an outside Reed-Solomon encoder, precoding and ternary
 mapping of the coded stream, one symbol per clk_sys edge.
 Assumes the RS encoder and MAC logic run on clk_sys, and the analog front
 end applies the square-root-of-two scaling to the symbol codes.
*/
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "tmi_regs.vh"

module tmi_tx_framer (
   input wire clk_sys,
   input wire resetn,
   input wire [7:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire pl_bit,
   input wire pl_valid,
   output wire pl_ready,
   output wire rs_bit,
   output wire rs_valid,
   input wire rs_ready,
   input wire cd_bit,
   input wire cd_valid,
   input wire cd_last,
   output wire cd_ready,
   output reg [1:0] sym_code,
   output reg sym_valid,
   output reg frame_start
);

   // One-hot frame states
   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_SYNC = 5'b00010;
   localparam [4:0] ST_CEST = 5'b00100;
   localparam [4:0] ST_HDR = 5'b01000;
   localparam [4:0] ST_PAY = 5'b10000;

   reg [4:0] state_q;
   reg [4:0] state_d;
   reg [11:0] cnt_q;
   reg [11:0] cnt_d;
   reg pay_en_q;
   reg disc_q;
   reg [1:0] scr_q;
   reg [`TMI_LEN_W-1:0] len_q;
   reg refused_q;
   reg underrun_q;
   reg [`TMI_HDR_W-1:0] hdr_q;
   reg h1_q;
   reg h2_q;
   reg pay_first_q;
   reg pad_act_q;
   reg [`TMI_LEN_W-1:0] pad_cnt_q;
   reg [10:0] blk_q;
   reg rs_bit_q;
   reg rs_valid_q;

   wire start_req;
   wire start_ok;
   wire pay_go;
   wire frame_end;
   reg src_bit;
   reg hist_clr;
   reg sym_en;

   // Base preamble tables, filled from constant phase arithmetic
   // Pure constants: a run-time phase generator would put a multiplier on
   // the symbol path for no gain, since the patterns never change
   wire [255:0] tbl_sync;
   wire [255:0] tbl_cest;

   genvar gi;
   generate
      for (gi = 0; gi < 256; gi = gi + 1) begin : g_tbl
         // Quarter-turn phase of the 16-term product; Re+Im>=0 for 0 and j
         localparam integer PA = ((gi % 4) * ((gi % 16) / 4)) % 4;
         localparam integer PB = (((gi / 16) % 4) * ((gi / 16) / 4)) % 4;
         localparam integer PH = (PA + PB) % 4;
         // Sixteenth-turn phase; Re>=Im holds from -135 to +45 degrees
         localparam integer PM = ((gi % 16) * (gi / 16)) % 16;
         assign tbl_sync[gi] = (PH < 2) ? 1'b1 : 1'b0;
         assign tbl_cest[gi] = (PM <= 2 || PM >= 10) ? 1'b1 : 1'b0;
      end
   endgenerate

   // A start in discovery mode is refused, never framed
   assign start_req = reg_wr && (reg_addr == `TMI_ADDR_CTRL) &&
                      reg_wdata[`TMI_CTRL_START];
   assign start_ok = start_req && (state_q == ST_IDLE) && !pad_act_q &&
                     !reg_wdata[`TMI_CTRL_DISC];
   // A zero length payload counts as no segment at all
   assign pay_go = reg_wdata[`TMI_CTRL_PAYLOAD] && (len_q != `TMI_LEN_RST);
   assign frame_end = (state_q == ST_PAY) && cd_valid && cd_last;

   // Register writes and sticky flags; a new event wins over a clear
   // The start bit itself is never stored, so the control word reads it as
   // zero; seed and discovery bits follow every control write, refused or not
   always @(posedge clk_sys) begin
      if (!resetn) begin
         pay_en_q <= 1'b0;
         disc_q <= 1'b0;
         scr_q <= 2'h0;
         len_q <= `TMI_LEN_RST;
         refused_q <= 1'b0;
         underrun_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `TMI_ADDR_CTRL) begin
            disc_q <= reg_wdata[`TMI_CTRL_DISC];
            scr_q <= reg_wdata[`TMI_CTRL_SCR_HI:`TMI_CTRL_SCR_LO];
            if (start_ok) begin
               pay_en_q <= pay_go;
            end
         end
         if (reg_wr && reg_addr == `TMI_ADDR_LEN && state_q == ST_IDLE && !pad_act_q) begin
            len_q <= reg_wdata[`TMI_LEN_W-1:0];
         end
         if (start_req && !start_ok) begin
            refused_q <= 1'b1;
         end else if (reg_wr && reg_addr == `TMI_ADDR_STAT &&
                      reg_wdata[`TMI_STAT_REFUSED]) begin
            refused_q <= 1'b0;
         end
         if (state_q == ST_PAY && !cd_valid) begin
            underrun_q <= 1'b1;
         end else if (reg_wr && reg_addr == `TMI_ADDR_STAT &&
                      reg_wdata[`TMI_STAT_UNDERRUN]) begin
            underrun_q <= 1'b0;
         end
      end
   end

   // Read data stand one cycle after the strobe; unmapped reads give zero
   // Zero outside the read slot lets a wired-OR bus gather several blocks
   // without a multiplexer in front of the master
   always @(posedge clk_sys) begin
      if (!resetn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `TMI_ADDR_CTRL: reg_rdata <= {26'h000_0000, scr_q, 1'b0, disc_q, pay_en_q, 1'b0};
            `TMI_ADDR_LEN: reg_rdata <= {12'h000, len_q};
            `TMI_ADDR_STAT: reg_rdata <= {24'h00_0000, state_q, underrun_q, refused_q,
                                          (state_q != ST_IDLE) || pad_act_q};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // Header word; fixed fields are constants, so no other value can leave
   // Bits leave from bit 0 upward, one per symbol, through the same precoder
   // as the preamble; it is latched at start so later writes cannot reach it
   always @(posedge clk_sys) begin
      if (!resetn) begin
         hdr_q <= {`TMI_HDR_W{1'b0}};
      end else if (start_ok) begin
         hdr_q <= {`TMI_HDR_W{1'b0}};
         hdr_q[`TMI_H_SCR+1:`TMI_H_SCR] <= reg_wdata[`TMI_CTRL_SCR_HI:`TMI_CTRL_SCR_LO];
         hdr_q[`TMI_H_PREFIX+1:`TMI_H_PREFIX] <= `TMI_PREFIX_VAL;
         hdr_q[`TMI_H_REQPREFIX+1:`TMI_H_REQPREFIX] <= `TMI_PREFIX_VAL;
         hdr_q[`TMI_H_NSEG+3:`TMI_H_NSEG] <= pay_go ? `TMI_NSEG_ONE : `TMI_NSEG_NONE;
         hdr_q[`TMI_H_NSU+5:`TMI_H_NSU] <= pay_go ? `TMI_NSU_ONE : `TMI_NSU_NONE;
         hdr_q[`TMI_H_MODE+5:`TMI_H_MODE] <= `TMI_MODE_VAL;
         hdr_q[`TMI_H_LEN+`TMI_LEN_W-1:`TMI_H_LEN] <= pay_go ? len_q : `TMI_LEN_RST;
      end
   end

   // Frame sequencer: no training or midamble state exists at all
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q + 12'h001;
      case (state_q)
         ST_IDLE: begin
            // Counter parks at zero so the first sync symbol reads entry 0
            cnt_d = 12'h000;
            if (start_ok) begin
               state_d = ST_SYNC;
            end
         end
         ST_SYNC: begin
            if (cnt_q == `TMI_SYNC_LEN - 12'h001) begin
               state_d = ST_CEST;
               cnt_d = 12'h000;
            end
         end
         ST_CEST: begin
            if (cnt_q == `TMI_CE_LEN - 12'h001) begin
               state_d = ST_HDR;
               cnt_d = 12'h000;
            end
         end
         ST_HDR: begin
            if (cnt_q == `TMI_HDR_LEN - 12'h001) begin
               state_d = pay_en_q ? ST_PAY : ST_IDLE;
               cnt_d = 12'h000;
            end
         end
         ST_PAY: begin
            // Payload length is set by the coder's last flag, not by a count,
            // so the framer never needs to know the coded block size
            cnt_d = 12'h000;
            if (frame_end) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = 12'h000;
         end
      endcase
   end

   always @(posedge clk_sys) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         cnt_q <= 12'h000;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
      end
   end

   // Bit source per section and where the lag-2 history restarts
   always @* begin
      src_bit = 1'b0;
      hist_clr = 1'b0;
      sym_en = 1'b1;
      case (state_q)
         ST_SYNC: begin
            // Last 256 symbols use the inverted base pattern
            src_bit = tbl_sync[cnt_q[7:0]] ^ (cnt_q >= `TMI_SYNC_ALT);
            hist_clr = (cnt_q[7:0] == 8'h00);
         end
         ST_CEST: begin
            src_bit = tbl_cest[cnt_q[7:0]];
            hist_clr = (cnt_q[7:0] == 8'h00);
         end
         ST_HDR: begin
            src_bit = hdr_q[cnt_q[5:0]];
            hist_clr = (cnt_q == 12'h000);
         end
         ST_PAY: begin
            src_bit = cd_bit;
            hist_clr = pay_first_q;
         end
         default: begin
            sym_en = 1'b0;
         end
      endcase
   end

   // Lag-2 precoder and ternary mapper shared by every section
   // History restarts at each 256-symbol pattern, at the header and at the
   // payload, so a receiver can lock onto any section on its own; sharing one
   // precoder keeps the preamble and data levels scaled alike
   wire p2 = hist_clr ? 1'b0 : h2_q;
   wire p1 = hist_clr ? 1'b0 : h1_q;
   wire pc = src_bit ^ p2;
   // An underrun emits a zero symbol and holds the history
   wire sym_go = sym_en && (state_q != ST_PAY || cd_valid);

   always @(posedge clk_sys) begin
      if (!resetn) begin
         h1_q <= 1'b0;
         h2_q <= 1'b0;
         sym_code <= `TMI_SYM_ZERO;
         sym_valid <= 1'b0;
         frame_start <= 1'b0;
         pay_first_q <= 1'b0;
      end else begin
         // Single lane out; channel bonding is optional and not built here
         sym_valid <= sym_en;
         frame_start <= (state_q == ST_SYNC) && (cnt_q == 12'h000);
         if (state_q == ST_HDR) begin
            pay_first_q <= 1'b1;
         end else if (sym_go) begin
            pay_first_q <= 1'b0;
         end
         if (sym_go) begin
            h2_q <= p1;
            h1_q <= pc;
            // Difference of current and lag-2 precoded bits
            case ({p2, pc})
               2'b01: sym_code <= `TMI_SYM_POS;
               2'b10: sym_code <= `TMI_SYM_NEG;
               default: sym_code <= `TMI_SYM_ZERO;
            endcase
         end else begin
            sym_code <= `TMI_SYM_ZERO;
         end
      end
   end

   // Coded payload is taken only while the payload section runs
   // Ready stands through the whole section; a late coder shows up as zero
   // symbols and the underrun flag rather than as a stalled frame
   assign cd_ready = (state_q == ST_PAY);

   // Zero padding stage feeding the encoder; starts with the preamble so the
   // encoder has lead time, since the section must not stall mid-frame.
   // The bit for the encoder sits in a one-deep output register, so the
   // encoder sees a flop; the slot refills in the cycle it is taken, so a
   // ready encoder still receives one bit per clock.
   wire pad_data = (pad_cnt_q < len_q);
   wire [`TMI_LEN_W-1:0] pad_cnt_nx = pad_cnt_q + {{(`TMI_LEN_W-1){1'b0}}, 1'b1};
   wire slot_free = !rs_valid_q || rs_ready;
   wire pad_fire = pad_act_q && slot_free && (pad_data ? pl_valid : 1'b1);
   wire [10:0] blk_nx = (blk_q == `TMI_PAD_BLK - 11'h001) ? 11'h000 : blk_q + 11'h001;

   assign rs_valid = rs_valid_q;
   assign rs_bit = rs_bit_q;
   // Payload bits are taken only when they can move on at the same edge
   assign pl_ready = pad_act_q && pad_data && slot_free;

   always @(posedge clk_sys) begin
      if (!resetn) begin
         pad_act_q <= 1'b0;
         pad_cnt_q <= `TMI_LEN_RST;
         blk_q <= 11'h000;
         rs_bit_q <= 1'b0;
         rs_valid_q <= 1'b0;
      end else begin
         if (start_ok) begin
            pad_act_q <= pay_go;
            pad_cnt_q <= `TMI_LEN_RST;
            blk_q <= 11'h000;
         end else if (pad_fire) begin
            pad_cnt_q <= pad_cnt_nx;
            blk_q <= blk_nx;
            // Stop once data is spent and a 1792-bit block is complete
            if (pad_cnt_nx >= len_q && blk_nx == 11'h000) begin
               pad_act_q <= 1'b0;
            end
         end
         // Load the next padded bit, or empty the slot once the encoder took it
         if (pad_fire) begin
            rs_bit_q <= pad_data ? pl_bit : 1'b0;
            rs_valid_q <= 1'b1;
         end else if (rs_ready) begin
            rs_valid_q <= 1'b0;
         end
      end
   end

endmodule
